// ---- inc/sync_edge_pkg.sv ----
// Purpose: Constants for the sync edge sense and module halt register block
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes: Offsets of the three registers of the block are fixed here
package sync_edge_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_EDGE_STATUS = 8'h00;
  localparam logic [7:0] OFS_HALT_CTRL = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;

  // ----------------------------------------
  // Edge status fields
  // ----------------------------------------
  localparam int BIT_VERT_SYNC = 7;
  localparam int BIT_HORIZ_SYNC = 6;
  localparam int BIT_COMP_SYNC = 5;
  localparam int BIT_HORIZ_FLYBACK = 4;
  localparam int BIT_VERT_FLYBACK = 3;
  localparam int BIT_PRE_EQUAL = 2;
  localparam int BIT_HORIZ_LEVEL = 1;
  localparam int BIT_VERT_LEVEL = 0;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;

  // ----------------------------------------
  // Module halt fields
  // ----------------------------------------
  localparam int BIT_HALT_FREE_COUNTER = 13;
  localparam int BIT_HALT_TIMER01 = 12;
  localparam int BIT_HALT_TIMERXY_LINK = 8;
  localparam logic [15:0] HALT_RESET = 16'h3FFF;

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hw/sync_edge_sense_status.sv ----
// Purpose: Sync edge flags, live levels and module halt control over AXI4-Lite
// Assumes: All pins synchronous to aclk; standby_n is hardware standby, active low
// Notes: Besides reset and hardware standby, flags clear only by a zero write after being read as one
//
// Notes on behaviour
// - Rising edge on vertical sync pin sets flag bit 7.
// - Rising edge on horizontal sync pin sets flag bit 6.
// - Rising edge on composite sync pin sets flag bit 5.
// - Rising edge on horizontal flyback pin sets flag bit 4.
// - Rising edge on vertical flyback pin sets flag bit 3.
// - Writing one to a flag never sets it.
// - Zero write clears a flag only after it was read as one.
// - Internal horizontal edge inside mask interval sets flag bit 2.
// - Bit 1 reads the live internal horizontal level.
// - Bit 0 reads the live internal vertical level.
// - Reset and hardware standby clear the six flags; level bits follow pins.
// - Halt register bit 13 stops the free running counter.
// - Halt register bit 12 stops timer channels 0 and 1.
// - Halt register bit 8 stops timer channels X, Y and interconnect.
// - Reset and hardware standby load halt register with 3FFF.
// - Software standby leaves the halt register unchanged.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module sync_edge_sense_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby_n,
  input wire logic soft_standby,
  input wire logic vert_sync_in_pin,
  input wire logic horiz_sync_in_pin,
  input wire logic comp_sync_in_pin,
  input wire logic horiz_flyback_in_pin,
  input wire logic vert_flyback_in_pin,
  input wire logic internal_horiz_input,
  input wire logic internal_vert_input,
  input wire logic horiz_mask_interval,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic halt_free_counter,
  output logic halt_timer01,
  output logic halt_timerxy_link,
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic init;
  logic [5:0] flags;
  logic [5:0] armed;
  logic [5:0] irq_mask;
  logic [15:0] halt_ctrl;
  logic [5:0] prev_in;
  logic [5:0] now_in;
  logic [5:0] set_ev;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic [5:0] clr_ev;
  logic prev_valid;
  logic vert_sync_edge_flag;
  logic horiz_sync_edge_flag;
  logic comp_sync_edge_flag;
  logic horiz_flyback_edge_flag;
  logic vert_flyback_edge_flag;
  logic pre_equalization_flag;
  logic wr_status;
  logic wr_halt;
  logic wr_mask;
  logic rd_status;
  logic [31:0] status_word;
  logic [31:0] halt_word;
  logic [31:0] mask_word;
  logic [7:0] halt_high;
  logic [7:0] halt_low;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    word_addr = {a[7:2], 2'b00};
  endfunction

  function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
    hits = (word_addr(a) == ofs);
  endfunction

  function automatic logic rise_seen(input logic now_lvl, input logic old_lvl, input logic valid);
    rise_seen = valid && now_lvl && !old_lvl;
  endfunction

  function automatic logic next_flag(input logic cur, input logic set_in, input logic clr_in);
    next_flag = (cur && !clr_in) || set_in;
  endfunction

  assign init = !aresetn || !standby_n;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign wr_status = do_write && hits(aw_addr, sync_edge_pkg::OFS_EDGE_STATUS) && w_strb[0];
  assign wr_mask = do_write && hits(aw_addr, sync_edge_pkg::OFS_IRQ_MASK) && w_strb[0];
  assign wr_halt = do_write && hits(aw_addr, sync_edge_pkg::OFS_HALT_CTRL);
  assign rd_status = do_read && hits(s_axi_araddr, sync_edge_pkg::OFS_EDGE_STATUS);

  assign status_word = {24'h000000,
                        flags,
                        internal_horiz_input,
                        internal_vert_input};
  assign halt_word = {16'h0000, halt_ctrl};
  assign mask_word = {24'h000000, irq_mask, 2'b00};

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  assign now_in = {vert_sync_in_pin,
                   horiz_sync_in_pin,
                   comp_sync_in_pin,
                   horiz_flyback_in_pin,
                   vert_flyback_in_pin,
                   internal_horiz_input};

  always_ff @(posedge aclk) begin
    if (init) begin
      prev_in <= 6'h00;
    end else begin
      prev_in <= now_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      prev_valid <= 1'b0;
    end else begin
      prev_valid <= 1'b1;
    end
  end

  always_comb begin
    set_ev = 6'h00;

    set_ev[sync_edge_pkg::BIT_VERT_SYNC - 2] = rise_seen(now_in[5], prev_in[5], prev_valid);

    set_ev[sync_edge_pkg::BIT_HORIZ_SYNC - 2] = rise_seen(now_in[4], prev_in[4], prev_valid);

    set_ev[sync_edge_pkg::BIT_COMP_SYNC - 2] = rise_seen(now_in[3], prev_in[3], prev_valid);

    set_ev[sync_edge_pkg::BIT_HORIZ_FLYBACK - 2] = rise_seen(now_in[2], prev_in[2], prev_valid);

    set_ev[sync_edge_pkg::BIT_VERT_FLYBACK - 2] = rise_seen(now_in[1], prev_in[1], prev_valid);

    set_ev[sync_edge_pkg::BIT_PRE_EQUAL - 2] = prev_valid && horiz_mask_interval && (now_in[0] != prev_in[0]);
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sync_edge_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (word_addr(aw_addr))
        sync_edge_pkg::OFS_EDGE_STATUS,
        sync_edge_pkg::OFS_HALT_CTRL,
        sync_edge_pkg::OFS_IRQ_MASK: s_axi_bresp <= sync_edge_pkg::RESP_OKAY;
        default: s_axi_bresp <= sync_edge_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sync_edge_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sync_edge_pkg::RESP_OKAY;
      case (word_addr(s_axi_araddr))
        sync_edge_pkg::OFS_EDGE_STATUS: s_axi_rdata <= status_word;
        sync_edge_pkg::OFS_HALT_CTRL: s_axi_rdata <= halt_word;
        sync_edge_pkg::OFS_IRQ_MASK: s_axi_rdata <= mask_word;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= sync_edge_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Edge flags
  // ----------------------------------------
  // clear needs armed bit; ones ignored
  assign clr_ev = wr_status ? (armed & ~w_data[7:2]) : 6'h00;

  always_ff @(posedge aclk) begin
    if (init) begin
      armed <= 6'h00;
    end else if (rd_status) begin
      armed <= (armed & ~clr_ev) | flags;
    end else begin
      armed <= armed & ~clr_ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      vert_sync_edge_flag <= sync_edge_pkg::FLAGS_RESET[5];
    end else begin
      vert_sync_edge_flag <= next_flag(vert_sync_edge_flag, set_ev[5], clr_ev[5]);
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      horiz_sync_edge_flag <= sync_edge_pkg::FLAGS_RESET[4];
    end else begin
      horiz_sync_edge_flag <= next_flag(horiz_sync_edge_flag, set_ev[4], clr_ev[4]);
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      comp_sync_edge_flag <= sync_edge_pkg::FLAGS_RESET[3];
    end else begin
      comp_sync_edge_flag <= next_flag(comp_sync_edge_flag, set_ev[3], clr_ev[3]);
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      horiz_flyback_edge_flag <= sync_edge_pkg::FLAGS_RESET[2];
    end else begin
      horiz_flyback_edge_flag <= next_flag(horiz_flyback_edge_flag, set_ev[2], clr_ev[2]);
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      vert_flyback_edge_flag <= sync_edge_pkg::FLAGS_RESET[1];
    end else begin
      vert_flyback_edge_flag <= next_flag(vert_flyback_edge_flag, set_ev[1], clr_ev[1]);
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      pre_equalization_flag <= sync_edge_pkg::FLAGS_RESET[0];
    end else begin
      pre_equalization_flag <= next_flag(pre_equalization_flag, set_ev[0], clr_ev[0]);
    end
  end

  assign flags = {vert_sync_edge_flag,
                  horiz_sync_edge_flag,
                  comp_sync_edge_flag,
                  horiz_flyback_edge_flag,
                  vert_flyback_edge_flag,
                  pre_equalization_flag};

  // ----------------------------------------
  // Interrupt mask and output
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (init) begin
      irq_mask <= sync_edge_pkg::MASK_RESET;
    end else if (wr_mask) begin
      irq_mask <= w_data[7:2];
    end
  end

  assign irq = |(flags & irq_mask);

  // ----------------------------------------
  // Module halt control
  // ----------------------------------------
  // high byte, soft standby ignored
  always_ff @(posedge aclk) begin
    if (init) begin
      halt_high <= sync_edge_pkg::HALT_RESET[15:8];
    end else if (wr_halt && w_strb[1]) begin
      halt_high <= w_data[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (init) begin
      halt_low <= sync_edge_pkg::HALT_RESET[7:0];
    end else if (wr_halt && w_strb[0]) begin
      halt_low <= w_data[7:0];
    end
  end

  assign halt_ctrl = {halt_high, halt_low};

  assign halt_free_counter = halt_ctrl[sync_edge_pkg::BIT_HALT_FREE_COUNTER];
  assign halt_timer01 = halt_ctrl[sync_edge_pkg::BIT_HALT_TIMER01];
  assign halt_timerxy_link = halt_ctrl[sync_edge_pkg::BIT_HALT_TIMERXY_LINK];

endmodule

// ---- test/sync_edge_sva.sv ----
// Purpose: Port assertions for the sync edge block
// Assumes: One clock domain
// Notes: Bound to every design instance
`timescale 1ns/1ps
module sync_edge_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby_n,
  input wire logic vert_sync_in_pin,
  input wire logic comp_sync_in_pin,
  input wire logic internal_horiz_input,
  input wire logic internal_vert_input,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic halt_free_counter,
  input wire logic halt_timer01,
  input wire logic halt_timerxy_link,
  input wire logic irq
);
  // ------
  // Properties
  // ------
  logic [2:0] halts;
  assign halts = {halt_free_counter, halt_timer01, halt_timerxy_link};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == sync_edge_pkg::OFS_EDGE_STATUS;
  endsequence
  property p_halt_reset;
    $rose(aresetn) |-> halts == 3'h7;
  endproperty
  a_halt_reset: assert property (p_halt_reset) else $error("halt not set");
  property p_halt_sby;
    !standby_n |=> halts == 3'h7;
  endproperty
  a_halt_sby: assert property (p_halt_sby) else $error("halt not set");
  property p_halt_hold;
    $changed(halts) |-> $rose(s_axi_bvalid) || !$past(standby_n) || !$past(aresetn);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt moved");
  property p_irq_sby;
    !standby_n |=> !irq;
  endproperty
  a_irq_sby: assert property (p_irq_sby) else $error("irq after standby");
  property p_horiz_lvl;
    s_rd |=> s_axi_rvalid && s_axi_rdata[1] == $past(internal_horiz_input);
  endproperty
  a_horiz_lvl: assert property (p_horiz_lvl) else $error("horiz level");
  property p_vert_lvl;
    s_rd |=> s_axi_rvalid && s_axi_rdata[0] == $past(internal_vert_input);
  endproperty
  a_vert_lvl: assert property (p_vert_lvl) else $error("vert level");
  property p_vert_edge;
    $rose(vert_sync_in_pin) ##[2:4] s_rd |=> s_axi_rdata[7];
  endproperty
  a_vert_edge: assert property (p_vert_edge) else $error("vert flag");
  property p_comp_edge;
    $rose(comp_sync_in_pin) ##[2:4] s_rd |=> s_axi_rdata[5];
  endproperty
  a_comp_edge: assert property (p_comp_edge) else $error("comp flag");
endmodule
bind sync_edge_sense_status sync_edge_sva i_sva (.*);

// ---- test/sync_pin_source.sv ----
// Purpose: Pin source for the sync and flyback inputs
// Assumes: Pins move only after a rising aclk edge
// Notes: pulse bits 4 to 0 drive vert, horiz, comp, horiz flyback, vert flyback
`timescale 1ns/1ps
module sync_pin_source (
  input wire logic aclk,
  input wire logic [4:0] pulse,
  output logic vert_sync_in_pin,
  output logic horiz_sync_in_pin,
  output logic comp_sync_in_pin,
  output logic horiz_flyback_in_pin,
  output logic vert_flyback_in_pin
);
  logic [4:0] pins = 5'h00;
  always @(posedge aclk) begin
    pins <= pulse;
  end
  assign {vert_sync_in_pin, horiz_sync_in_pin, comp_sync_in_pin, horiz_flyback_in_pin, vert_flyback_in_pin} = pins;
endmodule

// ---- test/sync_edge_sense_status_tb.sv ----
// Purpose: Self-checking bench for the sync edge block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes: Pin pulses come from the pin source model
`timescale 1ns/1ps
module sync_edge_sense_status_tb;
  logic aclk = 1'h0, aresetn = 1'h0, standby_n = 1'h1, soft_standby = 1'h0;
  logic internal_horiz_input = 1'h0, internal_vert_input = 1'h0, horiz_mask_interval = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, e;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [4:0] pulse = 5'h00;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic halt_free_counter, halt_timer01, halt_timerxy_link;
  logic vert_sync_in_pin, horiz_sync_in_pin, comp_sync_in_pin, horiz_flyback_in_pin, vert_flyback_in_pin;
  localparam logic [7:0] st = sync_edge_pkg::OFS_EDGE_STATUS;
  localparam logic [7:0] ht = sync_edge_pkg::OFS_HALT_CTRL;
  localparam logic [7:0] mk = sync_edge_pkg::OFS_IRQ_MASK;
  int failures = 0, checks_done = 0, i;
  always #20 aclk = ~aclk;
  sync_edge_sense_status i_dut (.*);
  sync_pin_source i_pins (.*);
  // ------
  // Tasks
  // ------
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 50) begin
      failures++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [2:0] p;
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    p = 3'h7;
    for (n = 0; p != 3'h0 && n < 50; n++) begin
      @(posedge aclk);
      if (p[2] && s_axi_bvalid) r = s_axi_bresp;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
      p = p & ~{s_axi_bvalid, s_axi_wready, s_axi_awready};
    end
    guard(n);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [1:0] p;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    p = 2'h3;
    for (n = 0; p != 2'h0 && n < 50; n++) begin
      @(posedge aclk);
      if (p[1] && s_axi_rvalid) {d, r} = {s_axi_rdata, s_axi_rresp};
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h0;
      p = p & ~{s_axi_rvalid, s_axi_arready};
    end
    guard(n);
    chk(d, x);
  endtask
  task automatic pin(input int k);
    pulse <= 5'h01 << k;
    repeat (2) @(posedge aclk);
    pulse <= 5'h00;
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(st, 32'h0);
    rdc(ht, 32'h3FFF);
    chk({28'h0, halt_free_counter, halt_timer01, halt_timerxy_link, irq}, 32'hE);
    e = 32'h0;
    for (i = 4; i >= 0; i--) begin
      pin(i);
      e[i + 3] = 1'h1;
      rdc(st, e);
    end
    wr(st, 32'hFF);
    rdc(st, 32'hF8);
    wr(st, 32'h0);
    rdc(st, 32'h0);
    pin(4);
    wr(st, 32'h0);
    rdc(st, 32'h80);
    wr(st, 32'h0);
    internal_horiz_input <= 1'h1;
    repeat (2) @(posedge aclk);
    rdc(st, 32'h2);
    {horiz_mask_interval, internal_horiz_input, internal_vert_input} <= 3'h5;
    repeat (2) @(posedge aclk);
    rdc(st, 32'h5);
    for (i = 0; i < 3; i++) begin
      wr(mk, 32'h4 >> (i & 1));
      chk({31'h0, irq}, 32'h1 >> (i & 1));
    end
    wr(st, 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (i = 0; i < 3; i++) begin
      wr(ht, (i == 2) ? 32'h100 : 32'h2000 >> i);
      chk({29'h0, halt_free_counter, halt_timer01, halt_timerxy_link}, 32'h4 >> i);
    end
    pin(3);
    soft_standby <= 1'h1;
    rdc(ht, 32'h100);
    {soft_standby, standby_n} <= 2'h0;
    @(posedge aclk);
    standby_n <= 1'h1;
    rdc(ht, 32'h3FFF);
    rdc(st, 32'h1);
    rdc(8'h0C, 32'h0);
    chk({30'h0, r}, {30'h0, sync_edge_pkg::RESP_SLVERR});
    wr(8'h0C, 32'hFF);
    chk({30'h0, r}, {30'h0, sync_edge_pkg::RESP_SLVERR});
    conclude();
  end
endmodule
